// >>> flash_dev_model.sv
`default_nettype none
module flash_dev_model (
   input  wire logic       sck_i,
   input  wire logic       sel_n_i,
   input  wire logic [7:0] io_i,
   input  wire logic [7:0] oe_i,
   output logic [7:0]      io_o,
   output var int          edges_o,
   output logic [63:0]     cap_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] slot_r;
   initial begin
      edges_o = 0;
      cap_o = '0;
   end
   // ********************
   // Flash pair behaviour
   // ********************
   // Each rising clock is counted and the lane-zero bit is kept while it is driven.
   always @(posedge sck_i) begin
      edges_o <= edges_o + 1;
      if (oe_i[0]) begin
         cap_o <= {cap_o[62:0], io_i[0]};
      end
   end
   always @(negedge sck_i or posedge sel_n_i) begin
      if (sel_n_i) begin
         slot_r <= 4'h0;
      end else begin
         slot_r <= slot_r + 4'h1;
      end
   end
   // Both flashes return the slot number; a released bus shows its inverse.
   assign io_o = sel_n_i ? ~{slot_r, slot_r} : {slot_r, slot_r};
endmodule
`default_nettype wire

// >>> flash_pair_buffer.sv
`default_nettype none
module flash_pair_buffer #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 2
)(
   input  wire logic   clk_i,
   input  wire logic   rst_n_i,
   flash_stream_if.snk in_s,
   flash_stream_if.src out_s
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r;
   logic [AW-1:0]    rp_r;
   logic [AW:0]      cnt_r;
   logic             push;
   logic             pop;

   assign in_s.ready  = cnt_r != (AW+1)'(DEPTH);
   assign out_s.valid = cnt_r != '0;
   assign out_s.data  = mem_r[rp_r];
   assign push        = in_s.valid && in_s.ready;
   assign pop         = out_s.valid && out_s.ready;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wp_r] <= in_s.data;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// >>> flash_stream_if.sv
`default_nettype none
interface flash_stream_if #(parameter int W = 64) ();
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> flash_sync_toggle.sv
`default_nettype none
module flash_sync_toggle (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic tgl_i,
   output logic      pulse_o
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= tgl_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign pulse_o = s2_r ^ s3_r;
endmodule
`default_nettype wire

// >>> flash_xfer_chk.sv
`default_nettype none
module flash_xfer_chk (
   input wire logic        REF_CLK_I,
   input wire logic        ARST_N_I,
   input wire logic        LINK_CLK_I,
   input wire logic        START_I,
   input wire logic        START_READY_O,
   input wire logic        BUSY_O,
   input wire logic        DONE_O,
   input wire logic        MAP_REQ_I,
   input wire logic [31:0] MAP_ADDR_I,
   input wire logic        MAP_ERR_O,
   input wire logic [63:0] RDATA_O,
   input wire logic        RDATA_VALID_O,
   input wire logic        RDATA_READY_I,
   input wire logic        FLASH_SCK_O,
   input wire logic        FLASH_SEL_N_O,
   input wire logic [7:0]  FLASH_IO_OE_O
);
   timeunit 1ns;
   timeprecision 1ps;
   logic acc_m;
   logic in_win;
   assign acc_m = MAP_REQ_I && !START_I && START_READY_O;
   assign in_win = MAP_ADDR_I >= 32'h1800_0000 && MAP_ADDR_I <= 32'h1BFF_FFFF;
   // ********************
   // Request side
   // ********************
   start_busy_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      START_I && START_READY_O |=> BUSY_O) else $error("busy missing after start");
   busy_blocks_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      BUSY_O |-> !START_READY_O) else $error("ready while busy");
   done_pulse_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      DONE_O |-> $past(BUSY_O) ##1 !DONE_O) else $error("bad done pulse");
   map_reject_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      acc_m && !in_win |=> MAP_ERR_O && !BUSY_O) else $error("no map error");
   map_accept_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      acc_m && in_win |=> BUSY_O && !MAP_ERR_O) else $error("window read lost");
   rd_hold_a: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      RDATA_VALID_O && !RDATA_READY_I |=> RDATA_VALID_O && $stable(RDATA_O))
      else $error("read word lost");
   // ********************
   // Flash pins, then covers of the request side
   // ********************
   oe_sel_a: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
      |FLASH_IO_OE_O |-> !FLASH_SEL_N_O) else $error("drive without select");
   sck_sel_a: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
      FLASH_SCK_O |-> !FLASH_SEL_N_O) else $error("clock without select");
   sck_wide_a: assert property (@(posedge LINK_CLK_I) disable iff (!ARST_N_I)
      $rose(FLASH_SCK_O) |=> FLASH_SCK_O) else $error("clock high too short");
   done_c: cover property (@(posedge REF_CLK_I) DONE_O);
   err_c: cover property (@(posedge REF_CLK_I) MAP_ERR_O);
   stall_c: cover property (@(posedge REF_CLK_I) RDATA_VALID_O && !RDATA_READY_I);
endmodule
bind spi_flash_transfer_config flash_xfer_chk u_chk (
   .REF_CLK_I(REF_CLK_I), .ARST_N_I(ARST_N_I), .LINK_CLK_I(LINK_CLK_I), .START_I(START_I),
   .START_READY_O(START_READY_O), .BUSY_O(BUSY_O), .DONE_O(DONE_O), .MAP_REQ_I(MAP_REQ_I),
   .MAP_ADDR_I(MAP_ADDR_I), .MAP_ERR_O(MAP_ERR_O), .RDATA_O(RDATA_O),
   .RDATA_VALID_O(RDATA_VALID_O), .RDATA_READY_I(RDATA_READY_I),
   .FLASH_SCK_O(FLASH_SCK_O), .FLASH_SEL_N_O(FLASH_SEL_N_O), .FLASH_IO_OE_O(FLASH_IO_OE_O));
`default_nettype wire

// >>> flash_xfer_pkg.sv
`default_nettype none
package flash_xfer_pkg;
   typedef enum {ENG_IDLE, ENG_RUN, ENG_FIN} eng_state_t;
   typedef struct packed {
      logic        cmd_en;
      logic        ocmd_en;
      logic        dummy_en;
      logic        write;
      logic        dual;
      logic        hold;
      logic        ddr;
      logic [7:0]  cmd;
      logic [7:0]  ocmd;
      logic [3:0]  addr_en;
      logic [3:0]  opt_en;
      logic [3:0]  data_en;
      logic [31:0] addr;
      logic [31:0] opt;
      logic [2:0]  dummy_cnt;
      logic [1:0]  cmd_lw;
      logic [1:0]  ocmd_lw;
      logic [1:0]  addr_lw;
      logic [1:0]  opt_lw;
      logic [1:0]  data_lw;
      logic [63:0] wdata;
   } xfer_cfg_t;
endpackage
`default_nettype wire

// >>> spi_flash_transfer_config.sv
`include "spi_flash_transfer_config_regs.svh"
`default_nettype none
module spi_flash_transfer_config (
   input  wire logic        REF_CLK_I,
   input  wire logic        ARST_N_I,
   input  wire logic        LINK_CLK_I,
   input  wire logic        START_I,
   output logic             START_READY_O,
   output logic             BUSY_O,
   output logic             DONE_O,
   input  wire logic        MAP_REQ_I,
   input  wire logic [31:0] MAP_ADDR_I,
   output logic             MAP_ERR_O,
   input  wire logic        CMD_EN_I,
   input  wire logic [7:0]  CMD_I,
   input  wire logic [1:0]  CMD_LANES_I,
   input  wire logic        OCMD_EN_I,
   input  wire logic [7:0]  OCMD_I,
   input  wire logic [1:0]  OCMD_LANES_I,
   input  wire logic [3:0]  ADDR_EN_I,
   input  wire logic [31:0] ADDR_I,
   input  wire logic [1:0]  ADDR_LANES_I,
   input  wire logic [3:0]  OPT_EN_I,
   input  wire logic [31:0] OPT_I,
   input  wire logic [1:0]  OPT_LANES_I,
   input  wire logic        DUMMY_EN_I,
   input  wire logic [2:0]  DUMMY_CNT_I,
   input  wire logic [3:0]  DATA_EN_I,
   input  wire logic [1:0]  DATA_LANES_I,
   input  wire logic        DATA_WRITE_I,
   input  wire logic [63:0] WDATA_I,
   input  wire logic        DEV_CNT_I,
   input  wire logic        SEL_HOLD_I,
   input  wire logic        DDR_I,
   output logic [63:0]      RDATA_O,
   output logic             RDATA_VALID_O,
   input  wire logic        RDATA_READY_I,
   output logic             FLASH_SCK_O,
   output logic             FLASH_SEL_N_O,
   input  wire logic [7:0]  FLASH_IO_I,
   output logic [7:0]       FLASH_IO_O,
   output logic [7:0]       FLASH_IO_OE_O
);
   import flash_xfer_pkg::*;

   // ****************************************************************
   // Field decoding
   // ****************************************************************
   function automatic logic [3:0] lane_bits(input logic [1:0] code);
      return (code == `LANE_QUAD) ? 4'h4 : 4'h1;
   endfunction

   function automatic logic [5:0] addr_bits(input logic [3:0] en);
      case (en)
         `ADDR_EN_24: return 6'h18;
         `ADDR_EN_32: return 6'h20;
         default:     return 6'h00;
      endcase
   endfunction

   function automatic logic [5:0] opt_bits(input logic [3:0] en);
      case (en)
         `OPT_EN_3:    return 6'h08;
         `OPT_EN_32:   return 6'h10;
         `OPT_EN_321:  return 6'h18;
         `OPT_EN_3210: return 6'h20;
         default:      return 6'h00;
      endcase
   endfunction

   function automatic logic [6:0] data_bits(input logic [3:0] en, input logic dual);
      logic [6:0] b;
      case (en)
         `DATA_EN_8:  b = 7'h08;
         `DATA_EN_16: b = 7'h10;
         `DATA_EN_32: b = 7'h20;
         default:     b = 7'h00;
      endcase
      return dual ? {b[5:0], 1'b0} : b;
   endfunction

   function automatic logic [2:0] first_from(input logic [5:0] en, input logic [2:0] k);
      logic [2:0] r;
      r = `PH_NONE;
      for (int i = 5; i >= 0; i--) begin
         if (en[i] && (3'(i) >= k)) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction

   // ****************************************************************
   // Request side
   // ****************************************************************
   xfer_cfg_t   user_cfg;
   xfer_cfg_t   map_cfg;
   xfer_cfg_t   cfg_r;
   logic [31:0] map_off;
   logic        map_hit;
   logic        launch;
   logic        busy_r;
   logic        req_tgl_r;
   logic        done_r;
   logic        map_err_r;
   logic        done_pulse;
   logic        push_vld_r;
   logic [63:0] push_data_r;
   logic [63:0] rd_word_r;
   logic        done_tgl_r;

   flash_stream_if #(.W(64)) push_if ();
   flash_stream_if #(.W(64)) pop_if ();

   assign map_off = MAP_ADDR_I - `MAP_BASE;
   assign map_hit = (MAP_ADDR_I >= `MAP_BASE) && (MAP_ADDR_I <= `MAP_END);
   // A read word still on its way into the buffer counts as taken room.
   assign START_READY_O = !busy_r && !push_vld_r && push_if.ready;
   assign launch = START_READY_O && (START_I || (MAP_REQ_I && map_hit));

   always_comb begin
      user_cfg.cmd_en    = CMD_EN_I;
      user_cfg.ocmd_en   = OCMD_EN_I;
      user_cfg.dummy_en  = DUMMY_EN_I;
      user_cfg.write     = DATA_WRITE_I;
      user_cfg.dual      = DEV_CNT_I;
      user_cfg.hold      = SEL_HOLD_I;
      user_cfg.ddr       = DDR_I;
      user_cfg.cmd       = CMD_I;
      user_cfg.ocmd      = OCMD_I;
      user_cfg.addr_en   = ADDR_EN_I;
      user_cfg.opt_en    = OPT_EN_I;
      user_cfg.data_en   = DATA_EN_I;
      user_cfg.addr      = ADDR_I;
      user_cfg.opt       = OPT_I;
      user_cfg.dummy_cnt = DUMMY_CNT_I;
      user_cfg.cmd_lw    = CMD_LANES_I;
      user_cfg.ocmd_lw   = OCMD_LANES_I;
      user_cfg.addr_lw   = ADDR_LANES_I;
      user_cfg.opt_lw    = OPT_LANES_I;
      user_cfg.data_lw   = DATA_LANES_I;
      user_cfg.wdata     = WDATA_I;
      // A mapped read is a command, address sized by ADDR_EN_I, optional dummy and 32-bit read.
      map_cfg            = user_cfg;
      map_cfg.cmd_en     = 1'b1;
      map_cfg.ocmd_en    = 1'b0;
      map_cfg.opt_en     = 4'h0;
      map_cfg.write      = 1'b0;
      map_cfg.ddr        = 1'b0;
      map_cfg.data_en    = `DATA_EN_32;
      map_cfg.addr       = map_off;
   end

   always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         cfg_r <= '0;
      end else if (launch) begin
         cfg_r <= START_I ? user_cfg : map_cfg;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         busy_r    <= 1'b0;
         req_tgl_r <= 1'b0;
         done_r    <= 1'b0;
         map_err_r <= 1'b0;
      end else begin
         if (launch) begin
            busy_r    <= 1'b1;
            req_tgl_r <= ~req_tgl_r;
         end else if (done_pulse) begin
            busy_r <= 1'b0;
         end
         done_r    <= done_pulse;
         map_err_r <= START_READY_O && !START_I && MAP_REQ_I && !map_hit;
      end
   end

   // The read word is stable in the link domain once the done toggle arrives.
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         push_vld_r  <= 1'b0;
         push_data_r <= '0;
      end else begin
         push_vld_r <= done_pulse && !cfg_r.write
                       && (data_bits(cfg_r.data_en, 1'b0) != 7'h00);
         if (done_pulse) begin
            push_data_r <= rd_word_r;
         end
      end
   end

   assign push_if.valid = push_vld_r;
   assign push_if.data  = push_data_r;
   assign RDATA_VALID_O = pop_if.valid;
   assign RDATA_O       = pop_if.data;
   assign pop_if.ready  = RDATA_READY_I;
   assign BUSY_O        = busy_r;
   assign DONE_O        = done_r;
   assign MAP_ERR_O     = map_err_r;

   flash_pair_buffer #(.WIDTH(64), .DEPTH(2)) u_buf (
      .clk_i   (REF_CLK_I),
      .rst_n_i (ARST_N_I),
      .in_s    (push_if),
      .out_s   (pop_if)
   );

   flash_sync_toggle u_done_sync (
      .clk_i   (REF_CLK_I),
      .rst_n_i (ARST_N_I),
      .tgl_i   (done_tgl_r),
      .pulse_o (done_pulse)
   );

   // ****************************************************************
   // Link engine
   // ****************************************************************
   eng_state_t  st_r;
   logic        req_pulse;
   logic [2:0]  ph_r;
   logic [1:0]  slot_r;
   logic [6:0]  left_r;
   logic [63:0] sh_r;
   logic [63:0] rx_r;
   logic        sck_r;
   logic        sel_n_r;
   logic [7:0]  io_o_r;
   logic [7:0]  io_oe_r;
   logic [7:0]  io_s1_r;
   logic [7:0]  io_s2_r;
   logic [5:0]  ph_en;
   logic [1:0]  lane_code;
   logic [3:0]  w;
   logic [6:0]  stepb;
   logic        in_data;
   logic        split;
   logic        drive;
   logic        fast;
   logic        slot_last;
   logic [2:0]  nxt_ph;
   logic [6:0]  nxt_len;
   logic [63:0] nxt_sh;
   logic [7:0]  rb;

   flash_sync_toggle u_req_sync (
      .clk_i   (LINK_CLK_I),
      .rst_n_i (ARST_N_I),
      .tgl_i   (req_tgl_r),
      .pulse_o (req_pulse)
   );

   assign ph_en = {data_bits(cfg_r.data_en, 1'b0) != 7'h00,
                   cfg_r.dummy_en,
                   opt_bits(cfg_r.opt_en) != 6'h00,
                   addr_bits(cfg_r.addr_en) != 6'h00,
                   cfg_r.ocmd_en,
                   cfg_r.cmd_en};

   always_comb begin
      case (ph_r)
         `PH_CMD:  lane_code = cfg_r.cmd_lw;
         `PH_OCMD: lane_code = cfg_r.ocmd_lw;
         `PH_ADDR: lane_code = cfg_r.addr_lw;
         `PH_OPT:  lane_code = cfg_r.opt_lw;
         `PH_DATA: lane_code = cfg_r.data_lw;
         default:  lane_code = 2'h0;
      endcase
   end

   assign in_data   = ph_r == `PH_DATA;
   assign w         = (ph_r == `PH_DUMMY) ? 4'h1 : lane_bits(lane_code);
   assign split     = in_data && cfg_r.dual;
   assign stepb     = split ? {2'b00, w, 1'b0} : {3'b000, w};
   assign drive     = (ph_r != `PH_DUMMY) && !(in_data && !cfg_r.write);
   assign fast      = in_data && cfg_r.ddr && cfg_r.write;
   assign slot_last = slot_r == (fast ? 2'h1 : 2'h3);
   assign nxt_ph    = first_from(ph_en, (st_r == ENG_IDLE) ? 3'h0 : ph_r + 3'h1);

   always_comb begin
      nxt_sh = '0;
      case (nxt_ph)
         `PH_CMD: begin
            nxt_len = 7'h08;
            nxt_sh  = {cfg_r.cmd, 56'h0};
         end
         `PH_OCMD: begin
            nxt_len = 7'h08;
            nxt_sh  = {cfg_r.ocmd, 56'h0};
         end
         `PH_ADDR: begin
            nxt_len = {1'b0, addr_bits(cfg_r.addr_en)};
            nxt_sh  = (cfg_r.addr_en == `ADDR_EN_24) ? {cfg_r.addr[23:0], 40'h0}
                                                     : {cfg_r.addr, 32'h0};
         end
         `PH_OPT: begin
            nxt_len = {1'b0, opt_bits(cfg_r.opt_en)};
            nxt_sh  = {cfg_r.opt, 32'h0};
         end
         `PH_DUMMY: nxt_len = {4'h0, cfg_r.dummy_cnt} + 7'h01;
         `PH_DATA: begin
            nxt_len = data_bits(cfg_r.data_en, cfg_r.dual);
            nxt_sh  = cfg_r.wdata;
         end
         default: nxt_len = 7'h00;
      endcase
   end

   // Read lanes: one lane reads io1, four lanes read io3..0; the second
   // flash sits on io7..4 and its bits follow those of the first.
   always_comb begin
      rb = 8'h00;
      if (w == 4'h4) begin
         rb = cfg_r.dual ? {io_s2_r[3:0], io_s2_r[7:4]} : {4'h0, io_s2_r[3:0]};
      end else begin
         rb = cfg_r.dual ? {6'h00, io_s2_r[1], io_s2_r[5]} : {7'h00, io_s2_r[1]};
      end
   end

   always_ff @(posedge LINK_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         io_s1_r <= 8'h00;
         io_s2_r <= 8'h00;
      end else begin
         io_s1_r <= FLASH_IO_I;
         io_s2_r <= io_s1_r;
      end
   end

   always_ff @(posedge LINK_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         st_r       <= ENG_IDLE;
         ph_r       <= `PH_NONE;
         slot_r     <= 2'h0;
         left_r     <= 7'h00;
         sh_r       <= '0;
         rx_r       <= '0;
         rd_word_r  <= '0;
         done_tgl_r <= 1'b0;
         sel_n_r    <= 1'b1;
      end else begin
         case (st_r)
            ENG_IDLE: begin
               if (req_pulse) begin
                  sel_n_r <= 1'b0;
                  rx_r    <= '0;
                  ph_r    <= nxt_ph;
                  left_r  <= nxt_len;
                  sh_r    <= nxt_sh;
                  slot_r  <= 2'h0;
                  st_r    <= (nxt_ph == `PH_NONE) ? ENG_FIN : ENG_RUN;
               end
            end
            ENG_RUN: begin
               slot_r <= slot_last ? 2'h0 : slot_r + 2'h1;
               if (slot_r == 2'h0) begin
                  sh_r   <= sh_r << stepb;
                  left_r <= left_r - stepb;
               end
               if (slot_last) begin
                  if (in_data && !cfg_r.write) begin
                     rx_r <= (rx_r << stepb) | {56'h0, rb};
                  end
                  if (left_r == 7'h00) begin
                     ph_r   <= nxt_ph;
                     left_r <= nxt_len;
                     sh_r   <= nxt_sh;
                     st_r   <= (nxt_ph == `PH_NONE) ? ENG_FIN : ENG_RUN;
                  end
               end
            end
            ENG_FIN: begin
               rd_word_r  <= rx_r;
               done_tgl_r <= ~done_tgl_r;
               sel_n_r    <= cfg_r.hold ? sel_n_r : 1'b1;
               st_r       <= ENG_IDLE;
            end
            default: st_r <= ENG_IDLE;
         endcase
      end
   end

   // Serial clock: low in the first half of a bit slot, high in the second;
   // double rate writes flip it once per short slot.
   always_ff @(posedge LINK_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         sck_r <= 1'b0;
      end else if (st_r != ENG_RUN) begin
         sck_r <= 1'b0;
      end else if (fast) begin
         sck_r <= (slot_r == 2'h1) ? ~sck_r : sck_r;
      end else begin
         sck_r <= slot_last ? 1'b0 : (slot_r == 2'h1) ? 1'b1 : sck_r;
      end
   end

   always_ff @(posedge LINK_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         io_o_r  <= 8'h00;
         io_oe_r <= 8'h00;
      end else if (st_r != ENG_RUN || !drive) begin
         io_oe_r <= 8'h00;
      end else if (slot_r == 2'h0) begin
         if (w == 4'h4) begin
            io_o_r[3:0] <= sh_r[63:60];
            io_o_r[7:4] <= split ? sh_r[59:56] : sh_r[63:60];
         end else begin
            io_o_r[3:0] <= {3'h0, sh_r[63]};
            io_o_r[7:4] <= {3'h0, split ? sh_r[62] : sh_r[63]};
         end
         io_oe_r[3:0] <= (w == 4'h4) ? 4'hF : 4'h1;
         io_oe_r[7:4] <= cfg_r.dual ? ((w == 4'h4) ? 4'hF : 4'h1) : 4'h0;
      end
   end

   assign FLASH_SCK_O   = sck_r;
   assign FLASH_SEL_N_O = sel_n_r;
   assign FLASH_IO_O    = io_o_r;
   assign FLASH_IO_OE_O = io_oe_r;
endmodule
`default_nettype wire

// >>> spi_flash_transfer_config_regs.svh
`ifndef SPI_FLASH_TRANSFER_CONFIG_REGS_SVH
`define SPI_FLASH_TRANSFER_CONFIG_REGS_SVH
`define LANE_QUAD     2'h2
`define ADDR_EN_24    4'h7
`define ADDR_EN_32    4'hF
`define OPT_EN_3      4'h8
`define OPT_EN_32     4'hC
`define OPT_EN_321    4'hE
`define OPT_EN_3210   4'hF
`define DATA_EN_8     4'h8
`define DATA_EN_16    4'hC
`define DATA_EN_32    4'hF
`define MAP_BASE      32'h1800_0000
`define MAP_END       32'h1BFF_FFFF
`define PH_CMD        3'h0
`define PH_OCMD       3'h1
`define PH_ADDR       3'h2
`define PH_OPT        3'h3
`define PH_DUMMY      3'h4
`define PH_DATA       3'h5
`define PH_NONE       3'h6
`endif

// >>> tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import flash_xfer_pkg::*;
   logic        clk = 1'b0;
   logic        lclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        start = 1'b0;
   logic        mreq = 1'b0;
   logic        rrdy = 1'b0;
   logic [31:0] maddr = '0;
   xfer_cfg_t   c = '0;
   logic        rdy, busy, done, merr, rval, sck, seln;
   logic [63:0] rdata, cap;
   logic [7:0]  io_in, io_out, io_oe;
   logic [31:0] madr [5] = '{32'h1A00_0124, 32'h1800_0000, 32'h1BFF_FFFF,
                             32'h1C00_0000, 32'h17FF_FFFF};
   int          edges, e0, k;
   int          miscompares = 0;
   int          n_checks = 0;
   int          cyc = 0;
   always #12.5 clk = ~clk;
   always #32 lclk = ~lclk;
   spi_flash_transfer_config DUT (
      .REF_CLK_I(clk), .ARST_N_I(rst_n), .LINK_CLK_I(lclk), .START_I(start),
      .START_READY_O(rdy), .BUSY_O(busy), .DONE_O(done), .MAP_REQ_I(mreq),
      .MAP_ADDR_I(maddr), .MAP_ERR_O(merr), .CMD_EN_I(c.cmd_en), .CMD_I(c.cmd),
      .CMD_LANES_I(c.cmd_lw), .OCMD_EN_I(c.ocmd_en), .OCMD_I(c.ocmd),
      .OCMD_LANES_I(c.ocmd_lw), .ADDR_EN_I(c.addr_en), .ADDR_I(c.addr),
      .ADDR_LANES_I(c.addr_lw), .OPT_EN_I(c.opt_en), .OPT_I(c.opt), .OPT_LANES_I(c.opt_lw),
      .DUMMY_EN_I(c.dummy_en), .DUMMY_CNT_I(c.dummy_cnt), .DATA_EN_I(c.data_en),
      .DATA_LANES_I(c.data_lw), .DATA_WRITE_I(c.write), .WDATA_I(c.wdata),
      .DEV_CNT_I(c.dual), .SEL_HOLD_I(c.hold), .DDR_I(c.ddr), .RDATA_O(rdata),
      .RDATA_VALID_O(rval), .RDATA_READY_I(rrdy), .FLASH_SCK_O(sck), .FLASH_SEL_N_O(seln),
      .FLASH_IO_I(io_in), .FLASH_IO_O(io_out), .FLASH_IO_OE_O(io_oe));
   flash_dev_model u_flash (
      .sck_i(sck), .sel_n_i(seln), .io_i(io_out), .oe_i(io_oe), .io_o(io_in),
      .edges_o(edges), .cap_o(cap));
   // ********************
   // Access tasks
   // ********************
   task automatic complete_run();
      if (miscompares == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cnt(input int n);
      chk(64'(edges - e0), 64'(n));
   endtask
   // Called at a rising edge; a set m asks for a window read instead of a transfer.
   task automatic go(input logic m);
      e0 = edges;
      start <= !m;
      mreq <= m;
      do @(negedge clk); while (rdy !== 1'b1);
      @(posedge clk);
      start <= 1'b0;
      mreq <= 1'b0;
      do @(negedge clk); while (done !== 1'b1);
      @(posedge clk);
   endtask
   task automatic pop(input logic [63:0] exp);
      @(negedge clk);
      while (rval !== 1'b1) @(negedge clk);
      chk(rdata, exp);
      @(posedge clk);
      rrdy <= 1'b1;
      @(posedge clk);
      rrdy <= 1'b0;
   endtask
   function automatic xfer_cfg_t mk(logic [3:0] a, logic [3:0] o, logic [3:0] d,
                                    logic de, logic [2:0] n, logic du);
      mk = '0;
      mk.cmd_en = 1'b1;
      mk.cmd = 8'hA5;
      mk.addr_en = a;
      mk.addr = 32'hC3A5_5A3C;
      mk.opt_en = o;
      mk.opt = 32'h96E1_4B2D;
      mk.data_en = d;
      mk.write = 1'b1;
      mk.wdata = 64'hB4C3_87E1_0000_0000;
      mk.dummy_en = de;
      mk.dummy_cnt = n;
      mk.dual = du;
   endfunction
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         complete_run();
      end
   end
   // ********************
   // Test sequence
   // ********************
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      chk({rdy, seln, io_oe}, {2'b11, 8'h00});
      c <= mk(4'h0, 4'h0, 4'h0, 1'b0, 3'h0, 1'b0);
      go(1'b0);
      cnt(8);
      chk(cap[7:0], 8'hA5);
      c.cmd_lw <= 2'h2;
      go(1'b0);
      cnt(2);
      c.cmd_en <= 1'b0;
      c.ocmd_en <= 1'b1;
      c.ocmd <= 8'h3C;
      go(1'b0);
      cnt(8);
      chk(cap[7:0], 8'h3C);
      for (k = 0; k < 3; k++) begin
         c <= mk(k == 0 ? 4'h0 : k == 1 ? 4'h7 : 4'hF, 4'h0, 4'h0, 1'b0, 3'h0, 1'b0);
         go(1'b0);
         cnt(8 + (k == 0 ? 0 : k == 1 ? 24 : 32));
         if (k > 0) chk(cap[23:0], 24'hA5_5A3C);
         if (k == 2) chk(cap[31:24], 8'hC3);
      end
      c.addr_lw <= 2'h2;
      go(1'b0);
      cnt(16);
      for (k = 1; k < 5; k++) begin
         c <= mk(4'h0, 4'(4'hF << (4 - k)), 4'h0, 1'b0, 3'h0, 1'b0);
         go(1'b0);
         cnt(8 + 8 * k);
         chk(32'(cap[31:0] << (32 - 8 * k)), 32'h96E1_4B2D & ('1 << (32 - 8 * k)));
      end
      c.opt_lw <= 2'h2;
      go(1'b0);
      cnt(16);
      for (k = 0; k < 9; k++) begin
         c <= mk(4'h0, 4'h0, 4'h8, k < 8, 3'(k), 1'b0);
         go(1'b0);
         cnt(k < 8 ? 17 + k : 16);
         chk(cap[7:0], 8'hB4);
      end
      for (k = 0; k < 6; k++) begin
         c <= mk(4'h0, 4'h0, k % 3 == 0 ? 4'h8 : k % 3 == 1 ? 4'hC : 4'hF, 1'b0, 3'h0, k > 2);
         go(1'b0);
         cnt(8 + (8 << (k % 3)));
      end
      c <= mk(4'h0, 4'h0, 4'h8, 1'b0, 3'h0, 1'b0);
      @(posedge clk);
      c.data_lw <= 2'h2;
      go(1'b0);
      cnt(10);
      c.ddr <= 1'b1;
      go(1'b0);
      cnt(9);
      c <= mk(4'h0, 4'h0, 4'h8, 1'b0, 3'h0, 1'b0);
      @(posedge clk);
      c.write <= 1'b0;
      go(1'b0);
      c.dual <= 1'b1;
      c.data_en <= 4'hC;
      c.data_lw <= 2'h2;
      go(1'b0);
      @(negedge clk);
      chk(64'(rdy), 64'h0);
      pop(64'h33);
      pop(64'h8899_AABB);
      c <= mk(4'hF, 4'h0, 4'h0, 1'b0, 3'h0, 1'b0);
      for (k = 0; k < 5; k++) begin
         maddr <= madr[k];
         if (k < 3) begin
            go(1'b1);
            cnt(72);
            chk(cap[31:0], madr[k] - 32'h1800_0000);
            pop(64'h3333_3333);
         end else begin
            mreq <= 1'b1;
            @(posedge clk);
            mreq <= 1'b0;
            @(negedge clk);
            chk(64'(merr), 64'h1);
            @(posedge clk);
         end
      end
      c.hold <= 1'b1;
      go(1'b0);
      repeat (3) @(negedge clk);
      chk(64'(seln), 64'h0);
      @(posedge clk);
      c.hold <= 1'b0;
      go(1'b0);
      repeat (3) @(negedge clk);
      chk(64'(seln), 64'h1);
      complete_run();
   end
endmodule
`default_nettype wire
